// ==== core/bsc_tap_device.sv ====
// boundary-scan tap controller and upper scan cells of the processor
//
// Contract
// - control cells 150,151 and grouped 154-156
// - control cells cleared in test-logic-reset
// - output-only cells float under highz
// - drive-control uses only flagged latch cells
// - static test logic, clock may stop
// - controller keeps system clocks running otherwise
// - controller runs clocks two bus periods
// - free instructions interchange without system clocks
// - other instruction needs restarted system clocks
// - controller avoids driving into driven nets
// - trst forces reset state asynchronously
// - controller asserts trst at power-up
// - tms sampled on rising test clock
// - release trst safely on falling edge
// - tms low two clocks reaches idle
// - trst pulse holds reset until tms low
`timescale 1ns/10ps
`default_nettype none
module bsc_tap_device #(
  parameter int unsigned CHAIN = bsc_pkg::BS_LEN
) (
  bsc_link_if.dev               link,
  input  wire logic [CHAIN-1:0] pin_capture,
  output logic [CHAIN-1:0]      cell_update,
  output logic                  test_active,
  output logic                  addr_drive_enable_cell,
  output logic                  data_drive_enable_cell,
  output logic [2:0]            io_group_en,
  output logic                  output_only_en,
  output logic                  clock_free,
  output logic                  power_down
);

  typedef struct packed {
    bsc_pkg::bsc_tap_t          tap;
    logic [bsc_pkg::IR_LEN-1:0] ir;
    logic [bsc_pkg::IR_LEN-1:0] ir_sh;
    logic [CHAIN-1:0]           bs_sh;
    logic [CHAIN-1:0]           bs_upd;
    logic                       byp;
    logic                       tdo;
    logic                       tdo_oe;
    logic                       test_active;
    logic                       ab_en;
    logic                       db_en;
    logic [2:0]                 grp_en;
    logic                       oo_en;
    logic                       clock_free;
    logic                       power_down;
  } bsc_dev_t;

  bsc_dev_t r;
  bsc_dev_t next_r;
  logic     bs_sel;
  logic     drive;
  logic     free_ir;

  always_comb
  begin
    next_r = r;
    bs_sel = (r.ir == bsc_pkg::IR_EXTEST) || (r.ir == bsc_pkg::IR_SAMPLE) ||
             (r.ir == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR);
    // sixteen-state walk on the sampled tms
    case (r.tap)
      bsc_pkg::TAP_RESET:
        next_r.tap = link.tms ? bsc_pkg::TAP_RESET
                              : bsc_pkg::TAP_IDLE;
      bsc_pkg::TAP_IDLE:
        next_r.tap = link.tms ? bsc_pkg::TAP_SELDR : bsc_pkg::TAP_IDLE;
      bsc_pkg::TAP_SELDR:
        next_r.tap = link.tms ? bsc_pkg::TAP_SELIR : bsc_pkg::TAP_CAPDR;
      bsc_pkg::TAP_CAPDR:
        next_r.tap = link.tms ? bsc_pkg::TAP_EX1DR : bsc_pkg::TAP_SHDR;
      bsc_pkg::TAP_SHDR:
        next_r.tap = link.tms ? bsc_pkg::TAP_EX1DR : bsc_pkg::TAP_SHDR;
      bsc_pkg::TAP_EX1DR:
        next_r.tap = link.tms ? bsc_pkg::TAP_UPDR : bsc_pkg::TAP_PAUSDR;
      bsc_pkg::TAP_PAUSDR:
        next_r.tap = link.tms ? bsc_pkg::TAP_EX2DR : bsc_pkg::TAP_PAUSDR;
      bsc_pkg::TAP_EX2DR:
        next_r.tap = link.tms ? bsc_pkg::TAP_UPDR : bsc_pkg::TAP_SHDR;
      bsc_pkg::TAP_UPDR:
        next_r.tap = link.tms ? bsc_pkg::TAP_SELDR : bsc_pkg::TAP_IDLE;
      bsc_pkg::TAP_SELIR:
        next_r.tap = link.tms ? bsc_pkg::TAP_RESET : bsc_pkg::TAP_CAPIR;
      bsc_pkg::TAP_CAPIR:
        next_r.tap = link.tms ? bsc_pkg::TAP_EX1IR : bsc_pkg::TAP_SHIR;
      bsc_pkg::TAP_SHIR:
        next_r.tap = link.tms ? bsc_pkg::TAP_EX1IR : bsc_pkg::TAP_SHIR;
      bsc_pkg::TAP_EX1IR:
        next_r.tap = link.tms ? bsc_pkg::TAP_UPIR : bsc_pkg::TAP_PAUSIR;
      bsc_pkg::TAP_PAUSIR:
        next_r.tap = link.tms ? bsc_pkg::TAP_EX2IR : bsc_pkg::TAP_PAUSIR;
      bsc_pkg::TAP_EX2IR:
        next_r.tap = link.tms ? bsc_pkg::TAP_UPIR : bsc_pkg::TAP_SHIR;
      bsc_pkg::TAP_UPIR:
        next_r.tap = link.tms ? bsc_pkg::TAP_SELDR : bsc_pkg::TAP_IDLE;
      default:
        next_r.tap = bsc_pkg::TAP_RESET;
    endcase

    case (r.tap)
      bsc_pkg::TAP_RESET:
      begin
        next_r.ir = bsc_pkg::IR_BYPASS;
        // every control cell drops so no pin is driven by test logic
        next_r.bs_upd = r.bs_upd & ~bsc_pkg::CTL_MASK;
      end
      bsc_pkg::TAP_CAPIR:
        next_r.ir_sh = bsc_pkg::IR_CAPTURE;
      bsc_pkg::TAP_SHIR:
        next_r.ir_sh = {link.tdi, r.ir_sh[bsc_pkg::IR_LEN-1:1]};
      bsc_pkg::TAP_UPIR:
        next_r.ir = r.ir_sh;
      bsc_pkg::TAP_CAPDR:
      begin
        next_r.byp = 1'b0;
        // control cells read back their own latch; all other cells see pins
        if (bs_sel)
          next_r.bs_sh = (pin_capture & ~bsc_pkg::CTL_MASK) |
                         (r.bs_upd & bsc_pkg::CTL_MASK);
      end
      bsc_pkg::TAP_SHDR:
      begin
        if (bs_sel)
          next_r.bs_sh = {link.tdi, r.bs_sh[CHAIN-1:1]};
        else
          next_r.byp = link.tdi;
      end
      bsc_pkg::TAP_UPDR:
      begin
        if (r.ir == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR)
          next_r.bs_upd = (r.bs_sh & bsc_pkg::DRV_MASK) |
                          (r.bs_upd & ~bsc_pkg::DRV_MASK);
        else if (bs_sel)
          next_r.bs_upd = r.bs_sh;
      end
      default:
        next_r.bs_upd = r.bs_upd;
    endcase

    // serial out follows the register that the next state shifts
    next_r.tdo_oe = (next_r.tap == bsc_pkg::TAP_SHIR) ||
                    (next_r.tap == bsc_pkg::TAP_SHDR);
    if (next_r.tap == bsc_pkg::TAP_SHIR)
      next_r.tdo = next_r.ir_sh[0];
    else if (bs_sel)
      next_r.tdo = next_r.bs_sh[0];
    else
      next_r.tdo = next_r.byp;

    // pin control from the instruction in force after this edge
    drive = (next_r.ir == bsc_pkg::IR_EXTEST) ||
            (next_r.ir == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR);
    free_ir = drive || (next_r.ir == bsc_pkg::IR_HIGHZ) ||
              (next_r.ir == bsc_pkg::IR_POWER_DOWN_TEST_INSTR);
    next_r.test_active = free_ir;
    next_r.ab_en = drive && next_r.bs_upd[bsc_pkg::C_AB];
    next_r.db_en = drive && next_r.bs_upd[bsc_pkg::C_DB];
    // io.2 gates acknowledge, io.1 busy/lock/tip, io.0 start strobe
    next_r.grp_en = drive ? {next_r.bs_upd[bsc_pkg::C_IO2],
                             next_r.bs_upd[bsc_pkg::C_IO1],
                             next_r.bs_upd[bsc_pkg::C_IO0]}
                          : 3'h0;
    // indicator, request and status pins have no control cell
    next_r.oo_en = (next_r.ir != bsc_pkg::IR_HIGHZ) &&
                   (next_r.ir != bsc_pkg::IR_POWER_DOWN_TEST_INSTR);
    // once in this set, swapping among them needs no system clock
    next_r.clock_free = free_ir;
    next_r.power_down = next_r.ir == bsc_pkg::IR_POWER_DOWN_TEST_INSTR;
  end

  // all state is plain flops on the test clock: stopping it loses nothing
  always_ff @(posedge link.tck or negedge link.trst_n)
  begin
    if (!link.trst_n)
    begin
      r.tap         <= bsc_pkg::TAP_RESET;
      r.ir          <= bsc_pkg::IR_BYPASS;
      r.ir_sh       <= bsc_pkg::IR_CAPTURE;
      r.bs_sh       <= bsc_pkg::BS_RESET;
      r.bs_upd      <= bsc_pkg::BS_RESET;
      r.byp         <= 1'b0;
      r.tdo         <= 1'b0;
      r.tdo_oe      <= 1'b0;
      r.test_active <= 1'b0;
      r.ab_en       <= 1'b0;
      r.db_en       <= 1'b0;
      r.grp_en      <= 3'h0;
      r.oo_en       <= 1'b1;
      r.clock_free  <= 1'b0;
      r.power_down  <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign link.tdo               = r.tdo;
  assign link.tdo_oe            = r.tdo_oe;
  assign cell_update            = r.bs_upd;
  assign test_active            = r.test_active;
  assign addr_drive_enable_cell = r.ab_en;
  assign data_drive_enable_cell = r.db_en;
  assign io_group_en            = r.grp_en;
  assign output_only_en         = r.oo_en;
  assign clock_free             = r.clock_free;
  assign power_down             = r.power_down;

endmodule // bsc_tap_device
`default_nettype wire

// ==== core/bsc_tap_host.sv ====
// test controller that drives the serial test port from the system clock
`timescale 1ns/10ps
`default_nettype none
module bsc_tap_host #(
  parameter int unsigned CHAIN = bsc_pkg::BS_LEN
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  bsc_link_if.host              link,
  input  wire logic             test_disable,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire logic             cmd_is_ir,
  input  wire logic [5:0]       cmd_len,
  input  wire logic [CHAIN-1:0] cmd_data,
  output logic                  rsp_valid,
  output logic [CHAIN-1:0]      rsp_data,
  output logic                  clocks_may_stop
);

  typedef struct packed {
    bsc_pkg::bsc_host_st_t st;
    logic [7:0]            div;
    logic                  tck;
    logic                  tms;
    logic                  tdi;
    logic                  trst_n;
    logic [2:0]            sync;
    logic                  tdo_q;
    logic [6:0]            step;
    logic [6:0]            pre;
    logic [5:0]            len;
    logic                  is_ir;
    logic                  free;
    logic [CHAIN-1:0]      sr;
    logic [CHAIN-1:0]      res;
    logic                  ready;
    logic                  rsp_valid;
    logic [CHAIN-1:0]      rsp_data;
    logic                  pend;
    logic [7:0]            wait_cnt;
    logic                  may_stop;
  } bsc_host_t;

  bsc_host_t r;
  bsc_host_t next_r;
  logic      edge_now;
  logic      fall;
  logic      free_cmd;
  logic [6:0] shift_end;

  always_comb
  begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.sync = {r.sync[1:0], link.tdo_line};
    if (r.sync[1] == r.sync[2])
      next_r.tdo_q = r.sync[2];
    edge_now = r.div == 8'(bsc_pkg::TCK_HALF - 1);
    fall = edge_now && r.tck;
    next_r.div = edge_now ? 8'h00 : r.div + 8'h01;
    if (edge_now)
      next_r.tck = ~r.tck;
    shift_end = r.pre + 7'(r.len);
    free_cmd = (cmd_data[2:0] == bsc_pkg::IR_EXTEST) ||
               (cmd_data[2:0] == bsc_pkg::IR_HIGHZ) ||
               (cmd_data[2:0] == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR) ||
               (cmd_data[2:0] == bsc_pkg::IR_POWER_DOWN_TEST_INSTR);

    // clocks stay up two bus periods after first entry; counted before the
    // command decode so a non-free load taken in the expiry cycle still wins
    if (r.pend)
    begin
      next_r.wait_cnt = r.wait_cnt - 8'h01;
      if (r.wait_cnt == 8'h00)
      begin
        next_r.pend = 1'b0;
        next_r.may_stop = 1'b1;
      end
    end

    case (r.st)
      bsc_pkg::H_RST:
      begin
        next_r.tms = 1'b1;
        if (fall)
        begin
          next_r.step = r.step + 7'h01;
          // release only on a falling test clock with tms high
          if (r.step == 7'(bsc_pkg::RST_TCKS))
          begin
            next_r.trst_n = 1'b1;
            next_r.step = 7'h00;
            next_r.st = bsc_pkg::H_INIT;
          end
        end
      end
      bsc_pkg::H_INIT:
        if (fall)
        begin
          next_r.tms = 1'b0;
          next_r.step = r.step + 7'h01;
          if (r.step == 7'(bsc_pkg::IDLE_TCKS))
          begin
            next_r.st = bsc_pkg::H_READY;
            next_r.ready = 1'b1;
          end
        end
      bsc_pkg::H_READY:
        if (cmd_valid)
        begin
          next_r.ready = 1'b0;
          next_r.is_ir = cmd_is_ir;
          next_r.len = cmd_len;
          next_r.sr = cmd_data;
          next_r.pre = cmd_is_ir ? 7'h04 : 7'h03;
          next_r.step = 7'h00;
          next_r.free = cmd_is_ir && free_cmd;
          // other instructions need running clocks before loading
          if (cmd_is_ir && !free_cmd)
          begin
            next_r.may_stop = 1'b0;
            next_r.pend = 1'b0;
          end
          next_r.st = bsc_pkg::H_RUN;
        end
      bsc_pkg::H_RUN:
        if (fall)
        begin
          next_r.step = r.step + 7'h01;
          if (r.step < r.pre)
            next_r.tms = r.is_ir ? (r.step < 7'h02) : (r.step == 7'h00);
          else if (r.step < shift_end)
          begin
            next_r.tms = r.step == shift_end - 7'h01;
            next_r.tdi = r.sr[0];
            next_r.sr = r.sr >> 1;
            next_r.res = {r.tdo_q, r.res[CHAIN-1:1]};
          end
          else if (r.step == shift_end)
            next_r.tms = 1'b1;
          else if (r.step == shift_end + 7'h01)
            next_r.tms = 1'b0;
          else
          begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = r.res >> (7'(CHAIN) - 7'(r.len));
            next_r.ready = 1'b1;
            next_r.st = bsc_pkg::H_READY;
            if (r.free && !r.may_stop)
            begin
              next_r.pend = 1'b1;
              next_r.wait_cnt = 8'(bsc_pkg::FREE_CYC);
            end
          end
        end
      default:
        next_r.st = bsc_pkg::H_RST;
    endcase

    // disabled: test clock held low and trst held, so the port stays reset
    if (test_disable)
    begin
      next_r.tck = 1'b0;
      next_r.div = 8'h00;
      next_r.trst_n = 1'b0;
      next_r.tms = 1'b1;
      next_r.step = 7'h00;
      next_r.ready = 1'b0;
      next_r.st = bsc_pkg::H_RST;
      // the forced reset loads bypass, so the system clocks must run again
      next_r.may_stop = 1'b0;
      next_r.pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r          <= '0;
      r.st       <= bsc_pkg::H_RST;
      r.tms      <= 1'b1;
      r.trst_n   <= 1'b0;
      r.sync     <= 3'h7;
      r.tdo_q    <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign link.tck        = r.tck;
  assign link.tms        = r.tms;
  assign link.tdi        = r.tdi;
  assign link.trst_n     = r.trst_n;
  assign cmd_ready       = r.ready;
  assign rsp_valid       = r.rsp_valid;
  assign rsp_data        = r.rsp_data;
  assign clocks_may_stop = r.may_stop;

endmodule // bsc_tap_host
`default_nettype wire

// ==== pkg/bsc_link_if.sv ====
// serial test port link between the controller and the device
`timescale 1ns/10ps
`default_nettype none
interface bsc_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // undriven data-out line floats high through the board pull-up
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev (
    input  tck,
    input  tms,
    input  tdi,
    input  trst_n,
    output tdo,
    output tdo_oe
  );
  modport host (
    output tck,
    output tms,
    output tdi,
    output trst_n,
    input  tdo_line
  );
endinterface
`default_nettype wire

// ==== pkg/bsc_pkg.sv ====
// shared constants and types for the boundary-scan test port and its driver
package bsc_pkg;

  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SELDR  = 16'h0004,
    TAP_CAPDR  = 16'h0008,
    TAP_SHDR   = 16'h0010,
    TAP_EX1DR  = 16'h0020,
    TAP_PAUSDR = 16'h0040,
    TAP_EX2DR  = 16'h0080,
    TAP_UPDR   = 16'h0100,
    TAP_SELIR  = 16'h0200,
    TAP_CAPIR  = 16'h0400,
    TAP_SHIR   = 16'h0800,
    TAP_EX1IR  = 16'h1000,
    TAP_PAUSIR = 16'h2000,
    TAP_EX2IR  = 16'h4000,
    TAP_UPIR   = 16'h8000
  } bsc_tap_t;

  // instruction codes are local to this design
  localparam int unsigned IR_LEN = 3;
  localparam logic [2:0] IR_EXTEST    = 3'h0;
  localparam logic [2:0] IR_SAMPLE    = 3'h1;
  localparam logic [2:0] IR_HIGHZ     = 3'h2;
  localparam logic [2:0] IR_DRIVE_CONTROL_TEST_INSTR  = 3'h3;
  localparam logic [2:0] IR_POWER_DOWN_TEST_INSTR  = 3'h4;
  localparam logic [2:0] IR_BYPASS    = 3'h7;
  localparam logic [2:0] IR_CAPTURE   = 3'h1;

  // chain slice holds cells 148..183; index is bit minus base
  localparam int unsigned BS_BASE = 148;
  localparam int unsigned BS_LEN  = 36;
  localparam int unsigned C_LOCK  = 149 - BS_BASE;
  localparam int unsigned C_AB    = 150 - BS_BASE;
  localparam int unsigned C_DB    = 151 - BS_BASE;
  localparam int unsigned C_IO2   = 154 - BS_BASE;
  localparam int unsigned C_IO1   = 155 - BS_BASE;
  localparam int unsigned C_IO0   = 156 - BS_BASE;
  localparam int unsigned C_LAST  = 183 - BS_BASE;
  localparam logic [35:0] CTL_MASK = 36'h0000001cc;
  // output latch cells usable by drive-control instructions
  localparam logic [35:0] DRV_MASK = 36'h00007ea32;
  localparam logic [35:0] BS_RESET = 36'h000000000;

  // host timing
  localparam int unsigned SYS_CLK_NS  = 8;
  localparam int unsigned TCK_NS      = 80;
  localparam int unsigned TCK_HALF    = TCK_NS / (2 * SYS_CLK_NS);
  localparam int unsigned BCLK_NS     = 40;
  localparam int unsigned FREE_BCLKS  = 2;
  localparam int unsigned FREE_CYC    =
    (FREE_BCLKS * BCLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned RST_TCKS    = 2;
  localparam int unsigned IDLE_TCKS   = 2;

  typedef enum logic [3:0] {
    H_RST   = 4'h1,
    H_INIT  = 4'h2,
    H_READY = 4'h4,
    H_RUN   = 4'h8
  } bsc_host_st_t;

endpackage

// ==== testbench/boundary_scan_tap_control_tb.sv ====
// self-checking bench: controller and device joined by the test port
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_tap_control_tb;
  localparam int unsigned N = bsc_pkg::BS_LEN;
  localparam logic [2:0] SEQ [6] = '{bsc_pkg::IR_EXTEST, bsc_pkg::IR_HIGHZ,
    bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR, bsc_pkg::IR_POWER_DOWN_TEST_INSTR, bsc_pkg::IR_BYPASS,
    bsc_pkg::IR_EXTEST};
  logic         sys_clk;
  logic         resetn;
  logic         test_disable;
  logic         cmd_valid;
  logic         cmd_ready;
  logic         cmd_is_ir;
  logic [5:0]   cmd_len;
  logic [N-1:0] cmd_data;
  logic         rsp_valid;
  logic [N-1:0] rsp_data;
  logic         clocks_may_stop;
  logic [N-1:0] pin_capture;
  logic [N-1:0] cell_update;
  logic         test_active;
  logic         addr_drive_enable_cell;
  logic         data_drive_enable_cell;
  logic [2:0]   io_group_en;
  logic         output_only_en;
  logic         clock_free;
  logic         power_down;
  int           num_errors;
  int           comparisons;
  int           take_cnt;
  logic [31:0]  rng;
  logic [N-1:0] lat;
  logic [2:0]   ir;
  logic [N-1:0] r;

  bsc_link_if link ();
  bsc_tap_host i_bsc_tap_host (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .link            (link),
    .test_disable    (test_disable),
    .cmd_valid       (cmd_valid),
    .cmd_ready       (cmd_ready),
    .cmd_is_ir       (cmd_is_ir),
    .cmd_len         (cmd_len),
    .cmd_data        (cmd_data),
    .rsp_valid       (rsp_valid),
    .rsp_data        (rsp_data),
    .clocks_may_stop (clocks_may_stop)
  );
  bsc_tap_device i_bsc_tap_device (
    .link                   (link),
    .pin_capture            (pin_capture),
    .cell_update            (cell_update),
    .test_active            (test_active),
    .addr_drive_enable_cell (addr_drive_enable_cell),
    .data_drive_enable_cell (data_drive_enable_cell),
    .io_group_en            (io_group_en),
    .output_only_en         (output_only_en),
    .clock_free             (clock_free),
    .power_down             (power_down)
  );
  bsc_link_checker i_bsc_link_checker (
    .tck    (link.tck),
    .tms    (link.tms),
    .trst_n (link.trst_n),
    .tdo    (link.tdo),
    .tdo_oe (link.tdo_oe)
  );

  always
  begin
    #4 sys_clk = ~sys_clk;
  end

  // cycles from a taken command until the clocks may stop
  always @(posedge sys_clk)
  begin
    if (cmd_valid && cmd_ready)
      take_cnt <= 0;
    else if (!clocks_may_stop)
      take_cnt <= take_cnt + 1;
  end

  function automatic logic [31:0] xs();
    logic [31:0] v;
    v = rng ^ (rng << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    rng = v;
    return v;
  endfunction

  function automatic logic free_of(input logic [2:0] c);
    return c == bsc_pkg::IR_EXTEST || c == bsc_pkg::IR_HIGHZ ||
      c == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR || c == bsc_pkg::IR_POWER_DOWN_TEST_INSTR;
  endfunction

  task automatic chk(input logic [N-1:0] seen, input logic [N-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic run(input logic is_ir, input logic [5:0] len,
                     input logic [N-1:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_is_ir <= is_ir;
    cmd_len <= len;
    cmd_data <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 3000);
    chk(N'(rsp_valid), N'(1));
    r = rsp_data;
  endtask

  task automatic outs();
    logic ext;
    logic hz;
    ext = (ir == bsc_pkg::IR_EXTEST) || (ir == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR);
    hz = (ir == bsc_pkg::IR_HIGHZ) || (ir == bsc_pkg::IR_POWER_DOWN_TEST_INSTR);
    repeat (30) @(negedge sys_clk);
    chk(N'(test_active), N'(ext || hz));
    chk(N'(clock_free), N'(ext || hz));
    chk(N'(power_down), N'(ir == bsc_pkg::IR_POWER_DOWN_TEST_INSTR));
    chk(N'(output_only_en), N'(!hz));
    chk(N'(addr_drive_enable_cell), N'(lat[bsc_pkg::C_AB] & ext));
    chk(N'(data_drive_enable_cell), N'(lat[bsc_pkg::C_DB] & ext));
    chk(N'(io_group_en), N'({lat[bsc_pkg::C_IO2], lat[bsc_pkg::C_IO1],
      lat[bsc_pkg::C_IO0]} & {3{ext}}));
    chk(cell_update, lat);
  endtask

  task automatic ir_load(input logic [2:0] code);
    logic was;
    was = free_of(ir);
    run(1'b1, 6'd3, N'(code));
    chk(r, N'(1));
    if (!free_of(code))
      chk(N'(clocks_may_stop), N'(0));
    else if (was)
      chk(N'(clocks_may_stop), N'(1));
    else
    begin
      // held low for the bus periods that follow the first entry
      chk(N'(clocks_may_stop), N'(0));
      repeat (bsc_pkg::FREE_CYC - 1) @(negedge sys_clk);
      chk(N'(clocks_may_stop), N'(0));
      repeat (3) @(negedge sys_clk);
      chk(N'(clocks_may_stop), N'(1));
      // clocks may stop no earlier than 85 cycles after the take
      chk(N'(take_cnt >= 85), N'(1));
    end
    ir = code;
    outs();
  endtask

  task automatic dr_scan();
    logic [N-1:0] d;
    logic [N-1:0] p;
    logic [N-1:0] exp;
    logic [5:0]   len;
    logic         bnd;
    d = N'({xs(), xs()});
    p = N'({xs(), xs()});
    bnd = ir == bsc_pkg::IR_EXTEST || ir == bsc_pkg::IR_SAMPLE ||
      ir == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR;
    len = bnd ? 6'd36 : 6'(1 + xs() % 36);
    @(posedge sys_clk);
    pin_capture <= p;
    run(1'b0, len, d);
    if (bnd)
    begin
      exp = (lat & bsc_pkg::CTL_MASK) | (p & ~bsc_pkg::CTL_MASK);
      if (ir == bsc_pkg::IR_DRIVE_CONTROL_TEST_INSTR)
        lat = (lat & ~bsc_pkg::DRV_MASK) | (d & bsc_pkg::DRV_MASK);
      else
        lat = d;
    end
    else
      exp = {d[N-2:0], 1'b0} & ((N'(1) << len) - N'(1));
    chk(r, exp);
    outs();
  endtask

  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    test_disable = 1'b0;
    cmd_valid = 1'b0;
    cmd_is_ir = 1'b0;
    cmd_len = 6'h0;
    cmd_data = '0;
    pin_capture = '0;
    num_errors = 0;
    comparisons = 0;
    take_cnt = 0;
    rng = 32'd41720;
    lat = '0;
    ir = bsc_pkg::IR_BYPASS;
    r = '0;
    repeat (20) @(negedge sys_clk);
    chk(N'(link.trst_n), N'(0));
    chk(N'(cmd_ready), N'(0));
    @(posedge sys_clk);
    resetn <= 1'b1;
    outs();
    dr_scan();
    ir_load(bsc_pkg::IR_SAMPLE);
    dr_scan();
    foreach (SEQ[i])
    begin
      ir_load(SEQ[i]);
      dr_scan();
    end
    @(posedge sys_clk);
    test_disable <= 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(N'(link.trst_n), N'(0));
    chk(N'(cmd_ready), N'(0));
    chk(N'(clocks_may_stop), N'(0));
    lat = '0;
    ir = bsc_pkg::IR_BYPASS;
    outs();
    @(posedge sys_clk);
    test_disable <= 1'b0;
    dr_scan();
    close_out();
  end

  // the whole run needs under ten thousand cycles
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
endmodule // boundary_scan_tap_control_tb
`default_nettype wire

// ==== testbench/bsc_link_checker.sv ====
// assertions on the serial test port between controller and device
`timescale 1ns/10ps
`default_nettype none
module bsc_link_checker (
  input wire logic tck,
  input wire logic tms,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // reference walk, own numbering: 0 reset, 1 idle, 4 and 11 shift
  localparam logic [63:0] NX1 = 64'h2fefcc0287855920;
  localparam logic [63:0] NX0 = 64'h1bddbba146644311;
  logic [3:0] st;
  logic [3:0] next_st;
  logic       in_shift;

  always_comb
  begin
    next_st = tms ? NX1[{st, 2'b00} +: 4] : NX0[{st, 2'b00} +: 4];
    in_shift = (st == 4'h4) || (st == 4'hb);
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
      st <= 4'h0;
    else
      st <= next_st;
  end

  default clocking cb @(posedge tck); endclocking
  default disable iff (!trst_n);

  sequence idle_two;
    !tms [*2];
  endsequence
  sequence dr_walk;
    tms ##1 !tms [*2];
  endsequence
  sequence ir_walk;
    tms [*2] ##1 !tms [*2];
  endsequence

  chk_oe_track: assert property (tdo_oe == in_shift)
    else $error("data-out enable off the shift states");
  chk_shift_exit: assert property (tdo_oe && tms |=> !tdo_oe)
    else $error("shift state not left on mode high");
  chk_shift_stay: assert property (tdo_oe && !tms |=> tdo_oe)
    else $error("shift state left on mode low");
  chk_release_safe: assert property ($rose(trst_n) |-> tms ##1 idle_two)
    else $error("test reset released without safe mode sequence");
  chk_release_quiet: assert property ($rose(trst_n) |-> !tdo_oe [*3])
    else $error("data out enabled right after test reset");
  chk_dr_entry: assert property (((st == 4'h1) && !tms) ##1 dr_walk |=> tdo_oe)
    else $error("data scan walk did not reach shift");
  chk_ir_capture: assert property ((st == 4'h1) ##0 ir_walk |=> tdo ##1 !tdo)
    else $error("instruction capture pattern wrong");
  chk_ir_length: assert property ((st == 4'h1) ##0 ir_walk |=> tdo_oe [*3] ##1 !tdo_oe)
    else $error("instruction shift not three bits long");
endmodule // bsc_link_checker
`default_nettype wire
